/* design/pbdpr_regs.svh */
`ifndef PBDPR_REGS_SVH
`define PBDPR_REGS_SVH
// register offsets on the plain port
`define PBDPR_ADDR_CTRL 4'h0
`define PBDPR_ADDR_STAT 4'h1
// control register fields
`define PBDPR_CTRL_UP_PER 0
`define PBDPR_CTRL_DN_PER 1
// status register fields
`define PBDPR_STAT_UP_DPD 0
`define PBDPR_STAT_DN_DPD 1
`define PBDPR_STAT_UP_PERR 2
`define PBDPR_STAT_DN_PERR 3
`define PBDPR_CTRL_RST 2'h0
`endif

/* design/pbdpr_pkg.sv */
package pbdpr_pkg;
  typedef enum logic [1:0] {
    PBDPR_READ = 2'b00,
    PBDPR_POSTED = 2'b01,
    PBDPR_DELAYED = 2'b10
  } pbdpr_kind_type;
  typedef enum logic {
    PBDPR_DOWN = 1'b0,
    PBDPR_UP = 1'b1
  } pbdpr_dir_type;
  typedef enum logic {
    PBDPR_BUS_PRI = 1'b0,
    PBDPR_BUS_SEC = 1'b1
  } pbdpr_bus_type;
endpackage : pbdpr_pkg

/* design/pbdpr_top.sv */
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "pbdpr_regs.svh"
// Functional notes
// - the upstream data-parity-detected bit sets only for upstream read, posted or delayed writes erroring upstream with the upstream enable set.
// - the upstream data-parity-detected bit sets only while mastering upstream, on a sampled upstream error line or own detected error.
// - the downstream data-parity-detected bit sets only while mastering the downstream bus.
// - the downstream data-parity-detected bit sets on a sampled downstream error line or own detected error there.
// - the downstream data-parity-detected bit sets only for downstream read, posted or delayed writes erroring downstream with the downstream enable set.
// - the upstream error output is driven only as write target or read initiator upstream.
// - the upstream error output asserts only with the upstream response enable set.
// - the upstream error output asserts for upstream-bus errors on upstream reads and downstream posted or delayed writes.
// - the upstream error output also asserts when the downstream line is seen low while completing a downstream delayed write.
// - that delayed-write case needs both response enables set.
// - the upstream error output stays high for all downstream reads and all upstream writes.
// - the downstream error output is driven only as write target or read initiator downstream.
// - the downstream error output asserts only with the downstream response enable set.
// - the downstream error output asserts on downstream-bus errors or on the upstream line seen low while completing an upstream delayed write.
module pbdpr_top
  import pbdpr_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic EVT_I,
  input wire logic [1:0] KIND_I,
  input wire logic DIR_I,
  input wire logic BUS_I,
  input wire logic UP_MASTER_I,
  input wire logic DN_MASTER_I,
  input wire logic UP_WR_TARGET_I,
  input wire logic DN_WR_TARGET_I,
  input wire logic UP_RD_INIT_I,
  input wire logic DN_RD_INIT_I,
  input wire logic DW_COMPLETE_I,
  input wire logic UP_PARITY_ERR_N_I,
  input wire logic DN_PARITY_ERR_N_I,
  output logic UP_PARITY_ERR_N_O,
  output logic UP_PARITY_ERR_OE_N_O,
  output logic DN_PARITY_ERR_N_O,
  output logic DN_PARITY_ERR_OE_N_O,
  output logic UP_DPD_O,
  output logic DN_DPD_O
);
  // EVT_I marks a data parity error detected by this device on BUS_I for the
  // transaction classified by KIND_I/DIR_I; line sampling is handled separately
  logic [1:0] ctrl_q;
  logic up_dpd_q;
  logic dn_dpd_q;
  logic up_perr_n_q;
  logic dn_perr_n_q;
  logic [31:0] rdata_q;
  logic up_set;
  logic dn_set;
  logic up_assert;
  logic dn_assert;
  logic up_en;
  logic dn_en;
  logic up_line;
  logic dn_line;
  logic wr_ctrl;
  logic wr_stat;
  pbdpr_kind_type kind;
  pbdpr_dir_type dir;
  pbdpr_bus_type bus;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  assign kind = pbdpr_kind_type'(KIND_I);
  assign dir = pbdpr_dir_type'(DIR_I);
  assign bus = pbdpr_bus_type'(BUS_I);
  assign up_en = ctrl_q[`PBDPR_CTRL_UP_PER];
  assign dn_en = ctrl_q[`PBDPR_CTRL_DN_PER];
  assign up_line = !UP_PARITY_ERR_N_I;
  assign dn_line = !DN_PARITY_ERR_N_I;
  assign wr_ctrl = WR_I && hit(ADDR_I, `PBDPR_ADDR_CTRL);
  assign wr_stat = WR_I && hit(ADDR_I, `PBDPR_ADDR_STAT);

  always_comb begin
    // upstream status: upstream transactions erroring upstream, while mastering
    up_set = 1'b0;
    if (UP_MASTER_I && up_en) begin
      // a sampled line is already on its own bus, only own detection needs BUS_I
      if (dir == PBDPR_UP && ((EVT_I && bus == PBDPR_BUS_PRI) || up_line)) begin
        up_set = (kind != 2'b11);
      end
    end
    // downstream status: downstream transactions erroring downstream
    dn_set = 1'b0;
    if (DN_MASTER_I && dn_en) begin
      if (dir == PBDPR_DOWN && ((EVT_I && bus == PBDPR_BUS_SEC) || dn_line)) begin
        dn_set = (kind != 2'b11);
      end
    end
  end

  always_comb begin
    up_assert = 1'b0;
    dn_assert = 1'b0;
    if (up_en) begin
      if (EVT_I && bus == PBDPR_BUS_PRI) begin
        unique case (kind)
          PBDPR_READ: up_assert = (dir == PBDPR_UP) && UP_RD_INIT_I;
          PBDPR_POSTED, PBDPR_DELAYED:
            up_assert = (dir == PBDPR_DOWN) && UP_WR_TARGET_I;
          default: up_assert = 1'b0;
        endcase
      end
      // downstream delayed write completion seen erroring on the far bus
      if (dn_en && DW_COMPLETE_I && dn_line && kind == PBDPR_DELAYED
          && dir == PBDPR_DOWN && UP_WR_TARGET_I) begin
        up_assert = 1'b1;
      end
    end
    if (dn_en) begin
      if (EVT_I && bus == PBDPR_BUS_SEC) begin
        unique case (kind)
          PBDPR_READ: dn_assert = (dir == PBDPR_DOWN) && DN_RD_INIT_I;
          PBDPR_POSTED, PBDPR_DELAYED:
            dn_assert = (dir == PBDPR_UP) && DN_WR_TARGET_I;
          default: dn_assert = 1'b0;
        endcase
      end
      // upstream delayed write completion, same both-enable qualification
      if (up_en && DW_COMPLETE_I && up_line && kind == PBDPR_DELAYED
          && dir == PBDPR_UP && DN_WR_TARGET_I) begin
        dn_assert = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ctrl_q <= `PBDPR_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= WDATA_I[1:0];
    end
  end

  // set wins over a same-cycle write-one clear so no event is lost
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      up_dpd_q <= 1'b0;
      dn_dpd_q <= 1'b0;
    end else begin
      up_dpd_q <= up_set || (up_dpd_q && !(wr_stat && WDATA_I[`PBDPR_STAT_UP_DPD]));
      dn_dpd_q <= dn_set || (dn_dpd_q && !(wr_stat && WDATA_I[`PBDPR_STAT_DN_DPD]));
    end
  end

  // error outputs are registered, one cycle after detection; the enable
  // tracks the assertion so the line is released otherwise
  // kept active low so the pins come straight from a flop
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      up_perr_n_q <= 1'b1;
      dn_perr_n_q <= 1'b1;
    end else begin
      up_perr_n_q <= !up_assert;
      dn_perr_n_q <= !dn_assert;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rdata_q <= 32'h0;
    end else if (RD_I) begin
      rdata_q <= 32'h0;
      if (hit(ADDR_I, `PBDPR_ADDR_CTRL)) begin
        rdata_q[1:0] <= ctrl_q;
      end else if (hit(ADDR_I, `PBDPR_ADDR_STAT)) begin
        rdata_q[`PBDPR_STAT_UP_DPD] <= up_dpd_q;
        rdata_q[`PBDPR_STAT_DN_DPD] <= dn_dpd_q;
        rdata_q[`PBDPR_STAT_UP_PERR] <= !up_perr_n_q;
        rdata_q[`PBDPR_STAT_DN_PERR] <= !dn_perr_n_q;
      end
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign RDATA_O = rdata_q;
  assign UP_PARITY_ERR_N_O = up_perr_n_q;
  assign UP_PARITY_ERR_OE_N_O = up_perr_n_q;
  assign DN_PARITY_ERR_N_O = dn_perr_n_q;
  assign DN_PARITY_ERR_OE_N_O = dn_perr_n_q;
  assign UP_DPD_O = up_dpd_q;
  assign DN_DPD_O = dn_dpd_q;
endmodule : pbdpr_top

/* test/pbdpr_chk.sv */
`timescale 1ns/1ps
`include "pbdpr_regs.svh"
module pbdpr_chk (
  input wire logic MCLK_I, RST_I, WR_I, DIR_I, EVT_I, BUS_I, UP_MASTER_I, DN_MASTER_I,
  input wire logic UP_WR_TARGET_I, UP_RD_INIT_I, DN_WR_TARGET_I, DN_RD_INIT_I,
  input wire logic DN_PARITY_ERR_N_I, UP_PARITY_ERR_N_O, UP_PARITY_ERR_OE_N_O,
  input wire logic DN_PARITY_ERR_N_O, UP_DPD_O, DN_DPD_O,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic [1:0] KIND_I
);
  logic [1:0] en_q;
  // enables rebuilt from port traffic, the checker cannot see the register
  always_ff @(posedge MCLK_I) begin
    if (RST_I) en_q <= 2'h0;
    else if (WR_I && ADDR_I == `PBDPR_ADDR_CTRL) en_q <= WDATA_I[1:0];
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  sequence up_rd_err;
    EVT_I && !BUS_I && DIR_I && KIND_I == 2'h0 && UP_RD_INIT_I && en_q[0];
  endsequence
  chk_up_perr_en: assert property (!UP_PARITY_ERR_N_O |-> $past(en_q[0]))
    else $error("up perr en");
  chk_up_perr_role: assert property (!UP_PARITY_ERR_N_O |-> $past(UP_WR_TARGET_I | UP_RD_INIT_I))
    else $error("up perr role");
  chk_dn_perr_en: assert property (!DN_PARITY_ERR_N_O |-> $past(en_q[1]))
    else $error("dn perr en");
  chk_dn_perr_role: assert property (!DN_PARITY_ERR_N_O |-> $past(DN_WR_TARGET_I | DN_RD_INIT_I))
    else $error("dn perr role");
  chk_up_rd_err: assert property (up_rd_err |=> !UP_PARITY_ERR_N_O && !UP_PARITY_ERR_OE_N_O)
    else $error("up rd err");
  chk_up_dpd_cause: assert property ($rose(UP_DPD_O) |-> $past(UP_MASTER_I & DIR_I & en_q[0]))
    else $error("up dpd");
  chk_dn_dpd_cause: assert property ($rose(DN_DPD_O) |-> $past(DN_MASTER_I & !DIR_I & en_q[1]))
    else $error("dn dpd");
  chk_dn_dpd_line: assert property (DN_MASTER_I && !DIR_I && KIND_I != 2'h3 && en_q[1]
    && !DN_PARITY_ERR_N_I |=> DN_DPD_O) else $error("dn dpd line");
  chk_dpd_sticky: assert property (UP_DPD_O && !(WR_I && ADDR_I == `PBDPR_ADDR_STAT
    && WDATA_I[0]) |=> UP_DPD_O) else $error("dpd sticky");
endmodule : pbdpr_chk
bind pbdpr_top pbdpr_chk i_pbdpr_chk (.*);

/* test/pbdpr_agent.sv */
`timescale 1ns/1ps
module pbdpr_agent (
  input wire logic clk_i, rst_i, report_i, perr_n_i, oe_n_i,
  output logic line_o
);
  logic rep_n_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) rep_n_q <= 1'b1;
    else rep_n_q <= !report_i;
  end
  // pulled-up wire, so an idle line reads high, never the last value
  assign line_o = rep_n_q & (oe_n_i | perr_n_i);
endmodule : pbdpr_agent

/* test/tb_pbdpr_top.sv */
`timescale 1ns/1ps
`include "pbdpr_regs.svh"
module tb_pbdpr_top;
  logic MCLK_I = 0, RST_I = 1, WR_I = 0, RD_I = 0, EVT_I = 0, DIR_I = 0, BUS_I = 0;
  logic rl = 0, dw = 0, up_ln, dn_ln, UP_DPD_O, DN_DPD_O;
  logic UP_PARITY_ERR_N_O, UP_PARITY_ERR_OE_N_O, DN_PARITY_ERR_N_O, DN_PARITY_ERR_OE_N_O;
  logic [3:0] ADDR_I = 4'h0;
  logic [31:0] WDATA_I = 32'h0, RDATA_O;
  logic [1:0] KIND_I = 2'h0, rep = 2'h0;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  pbdpr_top i_pbdpr_top (.*, .UP_MASTER_I(rl), .DN_MASTER_I(rl), .UP_WR_TARGET_I(rl),
    .DN_WR_TARGET_I(rl), .UP_RD_INIT_I(rl), .DN_RD_INIT_I(rl), .DW_COMPLETE_I(dw),
    .UP_PARITY_ERR_N_I(up_ln), .DN_PARITY_ERR_N_I(dn_ln));
  pbdpr_agent i_pbdpr_agent_up (.clk_i(MCLK_I), .rst_i(RST_I), .report_i(rep[0]),
    .perr_n_i(UP_PARITY_ERR_N_O), .oe_n_i(UP_PARITY_ERR_OE_N_O), .line_o(up_ln));
  pbdpr_agent i_pbdpr_agent_dn (.clk_i(MCLK_I), .rst_i(RST_I), .report_i(rep[1]),
    .perr_n_i(DN_PARITY_ERR_N_O), .oe_n_i(DN_PARITY_ERR_OE_N_O), .line_o(dn_ln));
  always #50 MCLK_I = !MCLK_I;
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge MCLK_I);
    WR_I <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge MCLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge MCLK_I);
    RD_I <= 1'b0;
    #1 check("rdata", RDATA_O, exp);
  endtask : rd
  task automatic run(input logic [1:0] en, k, input logic d, b, e, r, w, input logic [1:0] f);
    logic pu, pd, su, sd;
    su = en[0] & r & d & ((e & !b) | f[0]);
    sd = en[1] & r & !d & ((e & b) | f[1]);
    pu = en[0] & r & ((e & !b & ((k == 2'h0) == d)) | (w & f[1] & en[1] & k == 2'h2 & !d));
    pd = en[1] & r & ((e & b & ((k == 2'h0) != d)) | (w & f[0] & en[0] & k == 2'h2 & d));
    wr(`PBDPR_ADDR_CTRL, {30'h0, en});
    // agents flag one clock late, so the report leads the transfer
    rep <= f;
    @(posedge MCLK_I);
    rep <= 2'h0;
    {KIND_I, DIR_I, BUS_I, EVT_I, rl, dw} <= {k, d, b, e, r, w};
    @(posedge MCLK_I);
    {EVT_I, rl, dw} <= 3'h0;
    #1 check("up_perr", UP_PARITY_ERR_N_O, !pu);
    check("up_oe", UP_PARITY_ERR_OE_N_O, !pu);
    check("dn_perr", DN_PARITY_ERR_N_O, !pd);
    check("dn_oe", DN_PARITY_ERR_OE_N_O, !pd);
    check("dpd", {UP_DPD_O, DN_DPD_O}, {su, sd});
    repeat (2) @(posedge MCLK_I);
    #1 check("dpd_hold", {UP_DPD_O, DN_DPD_O}, {su, sd});
    rd(`PBDPR_ADDR_STAT, {30'h0, sd, su});
    wr(`PBDPR_ADDR_STAT, 32'h3);
    #1 check("dpd_clr", {UP_DPD_O, DN_DPD_O}, 2'h0);
  endtask : run
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge MCLK_I);
    RST_I <= 1'b0;
    rd(`PBDPR_ADDR_CTRL, 32'h0);
    rd(4'h5, 32'h0);
    $display("test regs done");
    for (int m = 0; m < 64; m++) begin
      if (m[3:2] != 2'h3) run(m[5:4], m[3:2], m[1], m[0], 1, 1, 0, 2'h0);
    end
    for (int m = 0; m < 16; m++) run(m[3:2], 2'h2, m[0], 0, 0, 1, m[1], {!m[0], m[0]});
    for (int m = 0; m < 8; m++) run(2'h3, m[2:1], m[0], m[0], 1, 0, 1, 2'h3);
    $display("test table done");
    summarize();
  end
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
endmodule : tb_pbdpr_top
